// file: hw/ags_supervisor.sv
// Purpose: device-wide supervisor: send hold, prog mode, manual mode, heartbeat,
// Purpose: telegram spacing, alarm shutdown of the dimmer, control range select
// Assumes: APB slave on pclk; keys, button and bus level pins are asynchronous
// Notes: Notes on behaviour listed below
//
// The implementer's own choices: register access over APB and the placing of the registers.
`include "ags_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ags_supervisor #(
    parameter int TICK_CYCLES = `AGS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic key_a_pin,
    input wire logic key_b_pin,
    input wire logic prog_button_pin,
    input wire logic bus_power_pin,
    input wire logic bus_load_high_pin,
    input wire logic manual_enter,
    input wire logic rx_switch_valid,
    input wire logic rx_switch_value,
    input wire logic load_valid,
    input wire logic [7:0] load_temp,
    output ags_pkg::ags_telegram_t tx_telegram,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic exec_valid,
    output logic exec_value,
    output logic dimmer_enable,
    output logic range_1v,
    output logic prog_mode,
    output logic led_prog_red,
    output logic led_mode_red,
    output logic manual_active,
    output logic irq
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    function automatic logic [14:0] man_limit(input ags_pkg::ags_man_cfg_t m);
        unique case (m)
            ags_pkg::AGS_MAN_1MIN: man_limit = `AGS_MAN_1MIN_TICKS;
            ags_pkg::AGS_MAN_10MIN: man_limit = `AGS_MAN_10MIN_TICKS;
            ags_pkg::AGS_MAN_30MIN: man_limit = `AGS_MAN_30MIN_TICKS;
            default: man_limit = 15'h0000;
        endcase
    endfunction

    // pin synchronisers: stage 1 is read only by stage 2
    logic [4:0] sync1;
    logic [4:0] sync2;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end
        else
        begin
            sync1 <= {bus_load_high_pin, bus_power_pin, prog_button_pin, key_b_pin, key_a_pin};
            sync2 <= sync1;
        end
    end
    logic both_keys;
    logic both_keys_q;
    logic prog_btn_q;
    logic power_q;
    assign both_keys = sync2[0] & sync2[1];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            both_keys_q <= 1'b0;
            prog_btn_q <= 1'b0;
            power_q <= 1'b0;
        end
        else
        begin
            both_keys_q <= both_keys;
            prog_btn_q <= sync2[2];
            power_q <= sync2[3];
        end
    end
    logic keys_press;
    logic button_press;
    logic power_return;
    assign keys_press = both_keys & ~both_keys_q;
    assign button_press = sync2[2] & ~prog_btn_q;
    assign power_return = sync2[3] & ~power_q;

    // 100 ms tick shared by every slow timer
    logic [TW-1:0] tick_cnt;
    logic tick;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (tick_cnt == TW'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
        end
    end

    // register file
    logic [31:0] ctrl;
    logic [15:0] send_delay;
    logic [10:0] hb_period;
    logic [3:0] rate_gap;
    logic [`AGS_IRQ_W-1:0] irq_stat;
    logic [`AGS_IRQ_W-1:0] irq_mask;
    logic [`AGS_IRQ_W-1:0] irq_ev;
    logic wr_en;
    logic mapped;
    ags_pkg::ags_man_cfg_t man_cfg;
    assign wr_en = psel & penable & pready & pwrite;
    assign man_cfg = ags_pkg::ags_man_cfg_t'(ctrl[`AGS_CTRL_MAN_LSB +: 3]);
    always_comb
    begin
        unique case (paddr)
            `AGS_OFS_CTRL, `AGS_OFS_SEND_DELAY, `AGS_OFS_HB_PERIOD, `AGS_OFS_RATE_GAP,
            `AGS_OFS_STATUS, `AGS_OFS_IRQ_STAT, `AGS_OFS_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= `AGS_CTRL_RST;
            send_delay <= `AGS_SEND_DELAY_RST;
            hb_period <= `AGS_HB_PERIOD_RST;
            rate_gap <= `AGS_RATE_GAP_RST;
            irq_mask <= '0;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                `AGS_OFS_CTRL: ctrl <= {25'h0000000, pwdata[6:0]};
                `AGS_OFS_SEND_DELAY: send_delay <= pwdata[15:0];
                // out-of-range periods are clamped so the timer always fires
                `AGS_OFS_HB_PERIOD: hb_period <= (pwdata[10:0] == 11'h000) ? 11'h001 :
                    (pwdata[10:0] > `AGS_HB_MAX_MIN) ? `AGS_HB_MAX_MIN : pwdata[10:0];
                `AGS_OFS_RATE_GAP: rate_gap <= (pwdata[3:0] == 4'h0) ? 4'h1 :
                    (pwdata[3:0] > 4'ha) ? 4'ha : pwdata[3:0];
                `AGS_OFS_IRQ_MASK: irq_mask <= pwdata[`AGS_IRQ_W-1:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= '0;
        else if (wr_en && paddr == `AGS_OFS_IRQ_STAT)
            irq_stat <= (irq_stat & ~pwdata[`AGS_IRQ_W-1:0]) | irq_ev;
        else
            irq_stat <= irq_stat | irq_ev;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_mask);
    end

    // errors and send hold declared ahead of status read
    logic [2:0] err;
    logic [15:0] hold_cnt;
    logic send_hold;
    // one wait state: pready rises in the second access cycle with data registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite)
            begin
                unique case (paddr)
                    `AGS_OFS_CTRL: prdata <= ctrl;
                    `AGS_OFS_SEND_DELAY: prdata <= {16'h0000, send_delay};
                    `AGS_OFS_HB_PERIOD: prdata <= {21'h000000, hb_period};
                    `AGS_OFS_RATE_GAP: prdata <= {28'h0000000, rate_gap};
                    `AGS_OFS_STATUS: prdata <= {25'h0000000, send_hold, dimmer_enable,
                                                err, manual_active, prog_mode};
                    `AGS_OFS_IRQ_STAT: prdata <= {26'h0000000, irq_stat};
                    `AGS_OFS_IRQ_MASK: prdata <= {26'h0000000, irq_mask};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // send hold after power return; receive path never looks at it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_cnt <= 16'hffff;
        else if (!sync2[3])
            hold_cnt <= 16'hffff;
        else if (power_return)
            hold_cnt <= send_delay;
        else if (tick && hold_cnt != 16'h0000)
            hold_cnt <= hold_cnt - 16'h0001;
    end
    assign send_hold = (hold_cnt != 16'h0000) || !sync2[3];

    // programming mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prog_mode <= 1'b0;
        else if (button_press)
            prog_mode <= ~prog_mode;
        else if (keys_press && !manual_active && ctrl[`AGS_CTRL_FRONT_PROG])
            prog_mode <= ~prog_mode;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            led_prog_red <= 1'b0;
            led_mode_red <= 1'b0;
            range_1v <= 1'b0;
        end
        else
        begin
            led_prog_red <= prog_mode;
            led_mode_red <= prog_mode;
            range_1v <= ctrl[`AGS_CTRL_RANGE_1V];
        end
    end

    // manual operation
    ags_pkg::ags_op_state_t op_state;
    logic [14:0] man_cnt;
    logic man_exit;
    logic stored_valid;
    logic stored_value;
    assign man_exit = (op_state == ags_pkg::AGS_MANUAL) && (keys_press
        || (man_cfg != ags_pkg::AGS_MAN_NO_LIMIT && tick && man_cnt <= 15'h0001));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_state <= ags_pkg::AGS_NORMAL;
            man_cnt <= 15'h0000;
        end
        else
        begin
            unique case (op_state)
                ags_pkg::AGS_NORMAL:
                    if (manual_enter && man_cfg != ags_pkg::AGS_MAN_OFF
                        && man_cfg <= ags_pkg::AGS_MAN_NO_LIMIT)
                    begin
                        op_state <= ags_pkg::AGS_MANUAL;
                        man_cnt <= man_limit(man_cfg);
                    end
                ags_pkg::AGS_MANUAL:
                    if (man_exit)
                        op_state <= ags_pkg::AGS_NORMAL;
                    else if (tick && man_cnt != 15'h0000)
                        man_cnt <= man_cnt - 15'h0001;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stored_valid <= 1'b0;
            stored_value <= 1'b0;
            exec_valid <= 1'b0;
            exec_value <= 1'b0;
            manual_active <= 1'b0;
        end
        else
        begin
            manual_active <= (op_state == ags_pkg::AGS_MANUAL) && !man_exit;
            exec_valid <= 1'b0;
            if (op_state == ags_pkg::AGS_MANUAL && rx_switch_valid)
            begin
                stored_valid <= 1'b1;
                stored_value <= rx_switch_value;
            end
            else if (op_state == ags_pkg::AGS_NORMAL && rx_switch_valid)
            begin
                exec_valid <= 1'b1;
                exec_value <= rx_switch_value;
            end
            if (man_exit)
            begin
                stored_valid <= 1'b0;
                exec_valid <= stored_valid | rx_switch_valid;
                exec_value <= rx_switch_valid ? rx_switch_value : stored_value;
            end
        end
    end

    // error detection from the load section
    logic [5:0] ncv_cnt;
    logic [2:0] err_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ncv_cnt <= 6'h00;
            err <= 3'h0;
            err_q <= 3'h0;
            dimmer_enable <= 1'b0;
        end
        else
        begin
            if (load_valid)
                ncv_cnt <= 6'h00;
            else if (tick && ncv_cnt <= `AGS_NCV_TICKS)
                ncv_cnt <= ncv_cnt + 6'h01;
            if (load_valid)
            begin
                err[0] <= (load_temp >= `AGS_TEMP_LIMIT_C);
                err[1] <= (load_temp >= `AGS_TEMP_LIMIT_C);
            end
            err[2] <= !load_valid && (ncv_cnt > `AGS_NCV_TICKS);
            err_q <= err;
            dimmer_enable <= (err == 3'h0);
        end
    end

    // transmit arbiter: alarms before heartbeat
    logic [2:0] alarm_pend;
    logic hb_pend;
    logic [19:0] hb_cnt;
    logic [3:0] gap_cnt;
    logic sent;
    logic gap_block;
    assign sent = tx_valid & tx_ready;
    assign gap_block = ctrl[`AGS_CTRL_RATE_EN] && sync2[4] && gap_cnt != 4'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hb_cnt <= 20'h00000;
        else if (!ctrl[`AGS_CTRL_HB_EN] || hb_cnt == 20'h00000)
            hb_cnt <= 20'(hb_period * `AGS_TICKS_PER_MIN);
        else if (tick)
            hb_cnt <= hb_cnt - 20'h00001;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap_cnt <= 4'h0;
        else if (sent)
            gap_cnt <= rate_gap;
        else if (tick && gap_cnt != 4'h0)
            gap_cnt <= gap_cnt - 4'h1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_pend <= 3'h0;
            hb_pend <= 1'b0;
            tx_valid <= 1'b0;
            tx_telegram <= '0;
        end
        else
        begin
            alarm_pend <= alarm_pend | (err ^ err_q);
            hb_pend <= hb_pend | (ctrl[`AGS_CTRL_HB_EN] && tick && hb_cnt == 20'h00001);
            if (sent)
                tx_valid <= 1'b0;
            else if (!tx_valid && !send_hold && !gap_block)
            begin
                if (alarm_pend != 3'h0)
                begin
                    tx_valid <= 1'b1;
                    for (int i = 2; i >= 0; i--)
                    begin
                        if (alarm_pend[i])
                            tx_telegram <= '{obj: ags_pkg::ags_obj_t'(2'(i + 1)), value: err[i]};
                    end
                end
                else if (hb_pend)
                begin
                    tx_valid <= 1'b1;
                    tx_telegram <= '{obj: ags_pkg::AGS_OBJ_HEARTBEAT, value: 1'b1};
                end
            end
            // clear only the pending bit just launched; a new change re-arms it
            if (sent && tx_telegram.obj != ags_pkg::AGS_OBJ_HEARTBEAT)
                alarm_pend[2'(tx_telegram.obj) - 2'h1] <= (err[2'(tx_telegram.obj) - 2'h1]
                    ^ err_q[2'(tx_telegram.obj) - 2'h1]) | (tx_telegram.value
                    != err[2'(tx_telegram.obj) - 2'h1]);
            else if (sent)
                hb_pend <= ctrl[`AGS_CTRL_HB_EN] && tick && hb_cnt == 20'h00001;
        end
    end
    assign irq_ev = {sent && tx_telegram.obj == ags_pkg::AGS_OBJ_HEARTBEAT,
                     man_exit, (err == 3'h0) && (err_q != 3'h0), err & ~err_q};

    a_hold_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        send_hold && !tx_valid |=> !tx_valid) else $error("telegram left during hold");
    a_rx_in_hold: assert property (@(posedge pclk) disable iff (!presetn)
        send_hold && rx_switch_valid && op_state == ags_pkg::AGS_NORMAL |=> exec_valid)
        else $error("reception stalled by hold");
    a_front_off: assert property (@(posedge pclk) disable iff (!presetn)
        keys_press && !button_press && !ctrl[0] |=> $stable(prog_mode))
        else $error("front keys changed prog mode");
    a_button_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        button_press |=> prog_mode != $past(prog_mode)) else $error("button ignored");
    a_manual_store: assert property (@(posedge pclk) disable iff (!presetn)
        op_state == ags_pkg::AGS_MANUAL && !man_exit && rx_switch_valid |=> !exec_valid)
        else $error("telegram acted on in manual mode");
    a_manual_exec: assert property (@(posedge pclk) disable iff (!presetn)
        man_exit && stored_valid && !rx_switch_valid |=> exec_valid && exec_value
        == $past(stored_value)) else $error("stored telegram lost");
    a_gap_keep: assert property (@(posedge pclk) disable iff (!presetn)
        gap_block && !tx_valid |=> !tx_valid) else $error("spacing violated");
    a_dim_off: assert property (@(posedge pclk) disable iff (!presetn)
        err != 3'h0 |=> !dimmer_enable) else $error("dimmer on during error");
    a_dim_back: assert property (@(posedge pclk) disable iff (!presetn)
        err == 3'h0 |=> dimmer_enable) else $error("dimmer not restored");
    a_leds_red: assert property (@(posedge pclk) disable iff (!presetn)
        prog_mode |=> led_prog_red && led_mode_red) else $error("prog leds dark");
    c_alarm_sent: cover property (@(posedge pclk) disable iff (!presetn)
        sent && tx_telegram.obj != ags_pkg::AGS_OBJ_HEARTBEAT);
    c_heartbeat: cover property (@(posedge pclk) disable iff (!presetn)
        sent && tx_telegram.obj == ags_pkg::AGS_OBJ_HEARTBEAT);
    c_manual_exit: cover property (@(posedge pclk) disable iff (!presetn)
        man_exit ##1 exec_valid);
endmodule
`default_nettype wire

// file: inc/ags_cfg.svh
// Purpose: constants of the actuator supervisor (offsets, fields, resets, timing)
// Assumes: 100 MHz pclk; slow timers advance on a 100 ms tick
// Notes: included by bare name
`ifndef AGS_CFG_SVH
`define AGS_CFG_SVH
`define AGS_OFS_CTRL 12'h000
`define AGS_OFS_SEND_DELAY 12'h004
`define AGS_OFS_HB_PERIOD 12'h008
`define AGS_OFS_RATE_GAP 12'h00c
`define AGS_OFS_STATUS 12'h010
`define AGS_OFS_IRQ_STAT 12'h014
`define AGS_OFS_IRQ_MASK 12'h018
`define AGS_CTRL_FRONT_PROG 0
`define AGS_CTRL_HB_EN 1
`define AGS_CTRL_RATE_EN 2
`define AGS_CTRL_RANGE_1V 3
`define AGS_CTRL_MAN_LSB 4
`define AGS_CTRL_RST 32'h0000_0001
`define AGS_SEND_DELAY_RST 16'h0000
`define AGS_HB_PERIOD_RST 11'h001
`define AGS_RATE_GAP_RST 4'h1
`define AGS_IRQ_OVL 0
`define AGS_IRQ_OT 1
`define AGS_IRQ_NCV 2
`define AGS_IRQ_ERR_GONE 3
`define AGS_IRQ_MAN_END 4
`define AGS_IRQ_HB 5
`define AGS_IRQ_W 6
`define AGS_CLK_NS 10
`define AGS_TICK_NS 100_000_000
`define AGS_TICK_CYCLES (`AGS_TICK_NS / `AGS_CLK_NS)
`define AGS_TICKS_PER_MIN 20'd600
`define AGS_MAN_1MIN_TICKS 15'd600
`define AGS_MAN_10MIN_TICKS 15'd6000
`define AGS_MAN_30MIN_TICKS 15'd18000
`define AGS_HB_MAX_MIN 11'd1440
`define AGS_NCV_TIMEOUT_S 3
`define AGS_NCV_TICKS 6'd30
`define AGS_TEMP_LIMIT_C 8'h55
`endif

// file: inc/ags_pkg.sv
// Purpose: types of the actuator supervisor
// Assumes: constants live in ags_cfg.svh
// Notes: none
package ags_pkg;
    typedef enum logic [1:0] {AGS_OBJ_HEARTBEAT, AGS_OBJ_OVERLOAD, AGS_OBJ_OVERTEMP,
                              AGS_OBJ_NO_CTRL_V} ags_obj_t;
    typedef struct packed {
        ags_obj_t obj;
        logic value;
    } ags_telegram_t;
    typedef enum logic [2:0] {AGS_MAN_OFF, AGS_MAN_1MIN, AGS_MAN_10MIN, AGS_MAN_30MIN,
                              AGS_MAN_NO_LIMIT} ags_man_cfg_t;
    typedef enum {AGS_NORMAL, AGS_MANUAL} ags_op_state_t;
endpackage

// file: tb/ags_bus_stack.sv
// Purpose: bus stack model that accepts outgoing telegrams
// Assumes: valid/ready handshake on pclk
// Notes: ready comes 1..3 cycles after valid, so prompt and slow answers both occur
`timescale 1ns/1ps
`default_nettype none
module ags_bus_stack (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_valid,
    input wire ags_pkg::ags_telegram_t tx_telegram,
    output logic tx_ready
);
    ags_pkg::ags_telegram_t q[$];
    int t_q[$];
    int cyc = 0;
    int wait_n;
    always @(posedge pclk)
        cyc <= cyc + 1;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_ready <= 1'b0;
            wait_n <= 0;
        end
        else if (tx_valid && tx_ready)
        begin
            q.push_back(tx_telegram);
            t_q.push_back(cyc);
            tx_ready <= 1'b0;
            wait_n <= $urandom_range(0, 3);
        end
        else if (wait_n > 0)
            wait_n <= wait_n - 1;
        else if (tx_valid)
            tx_ready <= 1'b1;
    end
endmodule
`default_nettype wire

// file: tb/tb_actuator_general_supervisor.sv
// Purpose: self-checking bench of the actuator supervisor
// Assumes: TICK_CYCLES of 10, so one tick is 100 ns of sim time
// Notes: 10 and 30 min manual limits are only shown not to end after 1 min, to keep the run short
`include "ags_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_actuator_general_supervisor;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_v;
    logic pready, pslverr, err_v, last_exec;
    logic key_a = 0, key_b = 0, btn = 0, pwr = 0, load_hi = 0, man_in = 0;
    logic rx_v = 0, rx_val = 0, ld_v = 0, feed = 1, sw;
    logic [7:0] temp = 8'h14;
    ags_pkg::ags_telegram_t tx_tel;
    logic tx_valid, tx_ready, exec_valid, exec_value, dim, rng, prog, led_p, led_m, man, irq;
    int num_errors = 0, checked = 0, execs = 0, t_last, t_prev, t0, n0;
    ags_supervisor #(.TICK_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .key_a_pin(key_a), .key_b_pin(key_b),
        .prog_button_pin(btn), .bus_power_pin(pwr), .bus_load_high_pin(load_hi),
        .manual_enter(man_in), .rx_switch_valid(rx_v), .rx_switch_value(rx_val),
        .load_valid(ld_v), .load_temp(temp), .tx_telegram(tx_tel), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .exec_valid(exec_valid), .exec_value(exec_value),
        .dimmer_enable(dim), .range_1v(rng), .prog_mode(prog), .led_prog_red(led_p),
        .led_mode_red(led_m), .manual_active(man), .irq(irq));
    ags_bus_stack bus_u (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
        .tx_telegram(tx_tel), .tx_ready(tx_ready));
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (exec_valid === 1'b1)
        begin
            execs <= execs + 1;
            last_exec <= exec_value;
        end
    end
    // load section reports every 10 ticks, well inside the 3 s silence limit
    always
    begin
        repeat (100) @(posedge pclk);
        ld_v <= feed;
        @(posedge pclk);
        ld_v <= 1'b0;
    end
    function automatic logic exp_dim(input logic [7:0] t);
        return t < `AGS_TEMP_LIMIT_C;
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic exp_tx(input logic [1:0] o, input logic v, input int lim);
        int n;
        n = 0;
        while (bus_u.q.size() == 0 && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        if (bus_u.q.size() == 0)
            chk("tx_missing", 1, 0);
        else
        begin
            chk("tx", {o, v}, bus_u.q.pop_front());
            t_prev = t_last;
            t_last = bus_u.t_q.pop_front();
        end
    endtask
    task automatic keys(input logic a, input logic b, input logic p);
        key_a <= a;
        key_b <= b;
        btn <= p;
        wt(8);
        key_a <= 1'b0;
        key_b <= 1'b0;
        btn <= 1'b0;
        wt(8);
    endtask
    task automatic rx(input logic v);
        rx_val <= v;
        rx_v <= 1'b1;
        @(posedge pclk);
        rx_v <= 1'b0;
        wt(3);
    endtask
    task automatic enter_man;
        man_in <= 1'b1;
        @(posedge pclk);
        man_in <= 1'b0;
        wt(3);
    endtask
    task automatic finish_test;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        wt(60000);
        num_errors++;
        finish_test();
    end
    initial
    begin
        void'($urandom(46));
        wt(5);
        presetn <= 1'b1;
        wt(2);
        apb(0, `AGS_OFS_CTRL, 0);
        chk("ctrl_rst", `AGS_CTRL_RST, rd_v);
        apb(0, `AGS_OFS_HB_PERIOD, 0);
        chk("hb_rst", 32'h1, rd_v);
        apb(0, `AGS_OFS_RATE_GAP, 0);
        chk("gap_rst", 32'h1, rd_v);
        apb(0, 12'h01c, 0);
        chk("unmapped", 1, err_v);
        apb(1, `AGS_OFS_CTRL, 32'h9);
        // range output is registered one edge after the write lands
        wt(1);
        chk("range", 1, rng);
        apb(1, `AGS_OFS_CTRL, 32'h1);
        wt(1);
        chk("range", 0, rng);
        apb(0, `AGS_OFS_STATUS, 0);
        chk("hold_flag", 1, rd_v[6]);
        $display("test registers done");
        apb(1, `AGS_OFS_SEND_DELAY, 32'd20);
        apb(1, `AGS_OFS_IRQ_MASK, 32'h1);
        temp <= 8'h5a;
        wt(120);
        chk("dim_err", 0, dim);
        chk("held", 0, bus_u.q.size());
        n0 = execs;
        rx(1'b1);
        chk("rx_in_hold", n0 + 1, execs);
        pwr <= 1'b1;
        t0 = bus_u.cyc;
        // arbiter serves the lowest pending alarm object first
        exp_tx(ags_pkg::AGS_OBJ_OVERLOAD, 1, 400);
        chk("hold_time", 1, t_last - t0 >= 190);
        exp_tx(ags_pkg::AGS_OBJ_OVERTEMP, 1, 60);
        chk("irq_on", 1, irq);
        apb(1, `AGS_OFS_IRQ_STAT, 32'h1);
        wt(2);
        chk("irq_clr", 0, irq);
        temp <= 8'h14;
        exp_tx(ags_pkg::AGS_OBJ_OVERLOAD, 0, 150);
        exp_tx(ags_pkg::AGS_OBJ_OVERTEMP, 0, 60);
        wt(3);
        chk("dim_back", 1, dim);
        apb(0, `AGS_OFS_IRQ_STAT, 0);
        chk("err_gone", 1, rd_v[3]);
        $display("test alarms done");
        apb(1, `AGS_OFS_RATE_GAP, 32'd10);
        apb(1, `AGS_OFS_CTRL, 32'h5);
        load_hi <= 1'b1;
        temp <= 8'h5a;
        exp_tx(ags_pkg::AGS_OBJ_OVERLOAD, 1, 150);
        exp_tx(ags_pkg::AGS_OBJ_OVERTEMP, 1, 200);
        chk("gap", 1, t_last - t_prev >= 90);
        load_hi <= 1'b0;
        temp <= 8'h14;
        exp_tx(ags_pkg::AGS_OBJ_OVERLOAD, 0, 150);
        exp_tx(ags_pkg::AGS_OBJ_OVERTEMP, 0, 60);
        chk("no_gap", 1, t_last - t_prev < 20);
        feed <= 1'b0;
        wt(200);
        chk("ncv_early", 1, dim);
        exp_tx(ags_pkg::AGS_OBJ_NO_CTRL_V, 1, 300);
        chk("ncv_dim", 0, dim);
        feed <= 1'b1;
        exp_tx(ags_pkg::AGS_OBJ_NO_CTRL_V, 0, 150);
        $display("test rate and silence done");
        keys(0, 0, 1);
        chk("prog_btn", 3'b111, {prog, led_p, led_m});
        keys(1, 1, 0);
        chk("prog_front", 0, prog);
        apb(1, `AGS_OFS_CTRL, 32'h4);
        keys(1, 1, 0);
        chk("front_off", 0, prog);
        keys(0, 0, 1);
        chk("btn_always", 1, prog);
        keys(0, 0, 1);
        $display("test prog done");
        apb(1, `AGS_OFS_CTRL, 32'h1);
        enter_man();
        chk("man_off", 0, man);
        apb(1, `AGS_OFS_CTRL, 32'h41);
        enter_man();
        chk("man_on", 1, man);
        n0 = execs;
        repeat (3)
        begin
            sw = $urandom_range(0, 1);
            rx(sw);
        end
        chk("stored", n0, execs);
        keys(1, 1, 0);
        chk("man_exit", 0, man);
        chk("exec_last", {n0 + 1, sw}, {execs, last_exec});
        chk("no_toggle", 0, prog);
        // 10 and 30 min limits must still be active after 1 min
        for (int m = 2; m < 4; m++)
        begin
            apb(1, `AGS_OFS_CTRL, 32'h1 | (m << 4));
            enter_man();
            wt(6200);
            chk("man_long", 1, man);
            keys(1, 1, 0);
            chk("man_long_exit", 0, man);
        end
        apb(1, `AGS_OFS_CTRL, 32'h11);
        enter_man();
        rx(1'b1);
        wt(5850);
        chk("man_1min", 1, man);
        wt(300);
        chk("man_expire", 0, man);
        chk("exec_exp", 1, last_exec);
        $display("test manual done");
        repeat (4)
        begin
            temp <= $urandom_range(60, 110);
            wt(115);
            chk("dim_rand", exp_dim(temp), dim);
        end
        temp <= 8'h14;
        wt(115);
        bus_u.q.delete();
        bus_u.t_q.delete();
        apb(1, `AGS_OFS_CTRL, 32'h3);
        exp_tx(ags_pkg::AGS_OBJ_HEARTBEAT, 1, 6100);
        exp_tx(ags_pkg::AGS_OBJ_HEARTBEAT, 1, 6100);
        chk("hb_period", 1, t_last - t_prev inside {[5980:6020]});
        $display("test heartbeat done");
        finish_test();
    end
endmodule
`default_nettype wire
